/* src/lfs_laser_safety.sv */
// laser fault safety control: pin monitors, self-test, drive gating, registers
// How it works
// - with no fault the supply enable output is held low
// - a detected fault drives the supply enable output high
// - a detected fault also switches off the internal laser current source
// - a short to ground on binning or laser current pin is a fault
// - the binning pin is watched every clock; the laser current pin except during self-test and for two cycles after
// - every write to power config a starts the laser pin self-test
// - constant mode keeps laser on unless power-down input is low, a fault is latched or the self-test runs
// - shutter mode drives only in illumination window; a control bit selects
module lfs_laser_safety (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire lfs_pkg::lfs_sense_type sense,
    input wire logic power_down_n,
    input wire logic illum_window,
    output logic laser_supply_enable_n,
    output logic laser_drive_en,
    output logic [7:0] laser_power_cfg_a,
    output logic [7:0] laser_power_cfg_b,
    output lfs_pkg::lfs_test_drive_type test_drive,
    output logic irq
);
    `include "lfs_defines.svh"

    localparam logic [7:0] PHASE_LAST = 8'(`LFS_TEST_PHASE_CYC - 1);

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    logic [3:0] pins_s;
    lfs_pkg::lfs_sense_type sense_s;
    logic power_down_n_s;

    lfs_sync #(.WIDTH(4)) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({sense, power_down_n}),
        .sync_out(pins_s)
    );

    assign sense_s = pins_s[3:1];
    assign power_down_n_s = pins_s[0];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    logic wr_ctrl;
    logic wr_cfg_a;
    logic wr_cfg_b;
    logic wr_int_stat;
    logic wr_int_mask;

    // write strobes per register
    assign wr_ctrl = reg_wr && hit(reg_addr, `LFS_OFS_CTRL);
    assign wr_cfg_a = reg_wr && hit(reg_addr, `LFS_OFS_CFG_A);
    assign wr_cfg_b = reg_wr && hit(reg_addr, `LFS_OFS_CFG_B);
    assign wr_int_stat = reg_wr && hit(reg_addr, `LFS_OFS_INT_STAT);
    assign wr_int_mask = reg_wr && hit(reg_addr, `LFS_OFS_INT_MASK);

    // ------------------------------------------------------------------
    // self-test sequencer
    // ------------------------------------------------------------------
    lfs_pkg::lfs_test_state_type tst_q;
    lfs_pkg::lfs_test_state_type tst_d;
    logic [7:0] tcnt_q;
    logic [7:0] tcnt_d;
    logic test_done;
    logic test_fail;

    // each phase settles for a fixed time, then its comparator is judged
    always_comb begin
        tst_d = tst_q;
        tcnt_d = tcnt_q + 8'h01;
        test_done = 1'b0;
        test_fail = 1'b0;
        unique case (tst_q)
            lfs_pkg::LFS_T_IDLE: begin
                tcnt_d = 8'h00;
            end
            lfs_pkg::LFS_T_GND: begin
                if (tcnt_q == PHASE_LAST) begin
                    tcnt_d = 8'h00;
                    if (sense_s.lco_low) begin // short to ground
                        test_fail = 1'b1;
                        test_done = 1'b1;
                        tst_d = lfs_pkg::LFS_T_IDLE;
                    end else begin
                        tst_d = lfs_pkg::LFS_T_SUP;
                    end
                end
            end
            lfs_pkg::LFS_T_SUP: begin
                if (tcnt_q == PHASE_LAST) begin
                    tcnt_d = 8'h00;
                    if (sense_s.lco_high) begin // short to supply
                        test_fail = 1'b1;
                        test_done = 1'b1;
                        tst_d = lfs_pkg::LFS_T_IDLE;
                    end else begin
                        tst_d = lfs_pkg::LFS_T_DET;
                    end
                end
            end
            lfs_pkg::LFS_T_DET: begin
                if (tcnt_q == PHASE_LAST) begin
                    tcnt_d = 8'h00;
                    test_fail = !sense_s.lco_low; // detector must see injection
                    test_done = 1'b1;
                    tst_d = lfs_pkg::LFS_T_IDLE;
                end
            end
            default: begin
                tcnt_d = 8'h00;
                tst_d = lfs_pkg::LFS_T_IDLE;
            end
        endcase
        if (wr_cfg_a) begin // any config a write (re)starts the test
            tst_d = lfs_pkg::LFS_T_GND;
            tcnt_d = 8'h00;
            test_done = 1'b0;
            test_fail = 1'b0;
        end
    end

    // registers the sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tst_q <= lfs_pkg::LFS_T_IDLE;
            tcnt_q <= 8'h00;
        end else begin
            tst_q <= tst_d;
            tcnt_q <= tcnt_d;
        end
    end

    logic testing;
    assign testing = (tst_q != lfs_pkg::LFS_T_IDLE);

    // pin stimulus per phase
    assign test_drive.pull_up = (tst_q == lfs_pkg::LFS_T_GND);
    assign test_drive.pull_down = (tst_q == lfs_pkg::LFS_T_SUP);
    assign test_drive.inject = (tst_q == lfs_pkg::LFS_T_DET);

    // ------------------------------------------------------------------
    // fault latch, control and interrupt registers
    // ------------------------------------------------------------------
    logic fault_q;
    logic fault_d;
    logic shutter_q;
    logic shutter_d;
    logic fail_q;
    logic fail_d;
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_a_d;
    logic [7:0] cfg_b_q;
    logic [7:0] cfg_b_d;
    logic [2:0] int_stat_q;
    logic [2:0] int_stat_d;
    logic [2:0] int_mask_q;
    logic [2:0] int_mask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic pin_fault;
    logic fault_set;
    logic [2:0] events;
    logic drive_on;
    logic [1:0] tail_q;
    logic [1:0] tail_d;
    logic lco_blank;

    // lco stimulus is ours during test, so only rbin is judged then;
    // the synchroniser still carries the last injection for two cycles after
    assign lco_blank = testing || (|tail_q);
    assign pin_fault = sense_s.rbin_low || (sense_s.lco_low && !lco_blank);
    assign fault_set = pin_fault || test_fail;
    assign events = {test_fail, test_done, fault_set && !fault_q};

    // both modes gate on power-down, fault and self-test; shutter also on the frame window
    assign drive_on = !fault_q && !testing && power_down_n_s
        && (!shutter_q || illum_window);

    always_comb begin
        fault_d = fault_q;
        tail_d = {tail_q[0], testing}; // blanking tail after the test ends
        if (wr_ctrl && reg_wdata[`LFS_CTRL_FAULT_CLR]) begin
            fault_d = 1'b0;
        end
        if (fault_set) begin // set wins over clear
            fault_d = 1'b1;
        end
        shutter_d = wr_ctrl ? reg_wdata[`LFS_CTRL_SHUTTER] : shutter_q;
        cfg_a_d = wr_cfg_a ? reg_wdata[7:0] : cfg_a_q;
        cfg_b_d = wr_cfg_b ? reg_wdata[7:0] : cfg_b_q;
        fail_d = test_done ? test_fail : fail_q;
        int_mask_d = wr_int_mask ? reg_wdata[2:0] : int_mask_q;
        int_stat_d = int_stat_q;
        if (wr_int_stat) begin
            int_stat_d = int_stat_q & ~reg_wdata[2:0];
        end
        int_stat_d = int_stat_d | events;
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `LFS_OFS_CTRL: rdata_d[`LFS_CTRL_SHUTTER] = shutter_q;
                `LFS_OFS_CFG_A: rdata_d[7:0] = cfg_a_q;
                `LFS_OFS_CFG_B: rdata_d[7:0] = cfg_b_q;
                `LFS_OFS_STATUS: begin
                    rdata_d[`LFS_ST_FAULT] = fault_q;
                    rdata_d[`LFS_ST_TEST_BUSY] = testing;
                    rdata_d[`LFS_ST_TEST_FAIL] = fail_q;
                    rdata_d[`LFS_ST_POWER_DOWN] = !power_down_n_s;
                    rdata_d[`LFS_ST_DRIVE_ON] = laser_drive_en;
                end
                `LFS_OFS_INT_STAT: rdata_d[2:0] = int_stat_q;
                `LFS_OFS_INT_MASK: rdata_d[2:0] = int_mask_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // registers the control state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fault_q <= 1'b0;
            tail_q <= 2'h0;
            shutter_q <= `LFS_RST_SHUTTER;
            fail_q <= 1'b0;
            cfg_a_q <= `LFS_RST_CFG_A;
            cfg_b_q <= `LFS_RST_CFG_B;
            int_stat_q <= 3'h0;
            int_mask_q <= `LFS_RST_INT_MASK;
            rdata_q <= 32'h0000_0000;
        end else begin
            fault_q <= fault_d;
            tail_q <= tail_d;
            shutter_q <= shutter_d;
            fail_q <= fail_d;
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign laser_supply_enable_n = fault_q; // low when healthy
    assign laser_drive_en = drive_on; // source off on fault
    assign laser_power_cfg_a = cfg_a_q;
    assign laser_power_cfg_b = cfg_b_q;
    assign reg_rdata = rdata_q;
    assign irq = |(int_stat_q & int_mask_q);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_supply_follows_fault: assert property (
        $rose(laser_supply_enable_n) |-> $past(fault_set)
    ) else $error("supply enable rose without fault");

    a_fault_raises_en: assert property (
        fault_set |=> laser_supply_enable_n
    ) else $error("fault did not raise supply enable");

    a_source_off_fault: assert property (
        fault_set |=> !laser_drive_en
    ) else $error("current source on during fault");

    a_rbin_pin_fault: assert property (
        $rose(sense_s.rbin_low) |=> fault_q
    ) else $error("binning pin short missed");

    a_lco_watch_idle: assert property (
        (sense_s.lco_low && !lco_blank) |=> fault_q
    ) else $error("laser pin short missed while idle");

    a_cfg_write_test: assert property (
        wr_cfg_a |=> (tst_q == lfs_pkg::LFS_T_GND) && (tcnt_q == 8'h00)
    ) else $error("config a write did not start self-test");

    a_test_length: assert property (
        (wr_cfg_a ##1 !wr_cfg_a [*8]) |-> testing
    ) else $error("self-test ended too soon");

    a_powerdown_off: assert property (
        !power_down_n_s |-> !laser_drive_en
    ) else $error("laser driven in power-down");

    a_shutter_window: assert property (
        (shutter_q && !illum_window) |-> !laser_drive_en
    ) else $error("shutter mode drive outside window");

    a_test_fail_shut: assert property (
        test_fail |=> laser_supply_enable_n ##0 !laser_drive_en
    ) else $error("failed self-test did not shut laser");

    c_pin_fault: cover property ($rose(fault_q) && !testing);
    c_test_pass: cover property (test_done && !test_fail);
    c_test_fail: cover property (test_done && test_fail);
    c_constant_on: cover property (!shutter_q && laser_drive_en);

endmodule : lfs_laser_safety

/* shared/lfs_defines.svh */
// register offsets, field positions, reset values and timing counts of laser fault control
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LFS_OFS_CTRL 8'h00
`define LFS_OFS_CFG_A 8'h04
`define LFS_OFS_CFG_B 8'h08
`define LFS_OFS_STATUS 8'h0c
`define LFS_OFS_INT_STAT 8'h10
`define LFS_OFS_INT_MASK 8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LFS_CTRL_SHUTTER 0
`define LFS_CTRL_FAULT_CLR 1
`define LFS_ST_FAULT 0
`define LFS_ST_TEST_BUSY 1
`define LFS_ST_TEST_FAIL 2
`define LFS_ST_POWER_DOWN 3
`define LFS_ST_DRIVE_ON 4
`define LFS_INT_FAULT 0
`define LFS_INT_TEST_DONE 1
`define LFS_INT_TEST_FAIL 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LFS_RST_SHUTTER 1'b1
`define LFS_RST_CFG_A 8'h00
`define LFS_RST_CFG_B 8'h00
`define LFS_RST_INT_MASK 3'h0

// ----------------------------------------------------------------------
// timing: self-test phase settle time at a 5 ns clock
// ----------------------------------------------------------------------
`define LFS_CLK_PERIOD_PS 5000
`define LFS_TEST_PHASE_NS 1000
`define LFS_TEST_PHASE_CYC (((`LFS_TEST_PHASE_NS * 1000) + `LFS_CLK_PERIOD_PS - 1) / `LFS_CLK_PERIOD_PS)

`endif

/* shared/lfs_pkg.sv */
// types of the laser fault safety control
package lfs_pkg;

    // comparator outputs of the analog pin monitors
    typedef struct packed {
        logic rbin_low; // binning pin pulled near ground
        logic lco_low;  // laser current pin near ground
        logic lco_high; // laser current pin near supply
    } lfs_sense_type;

    // stimulus applied to the laser current pin during self-test
    typedef struct packed {
        logic pull_up;
        logic pull_down;
        logic inject;
    } lfs_test_drive_type;

    typedef enum logic [2:0] {
        LFS_T_IDLE = 3'b000,
        LFS_T_GND = 3'b001,
        LFS_T_SUP = 3'b010,
        LFS_T_DET = 3'b011
    } lfs_test_state_type;

endpackage : lfs_pkg

/* src/lfs_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
module lfs_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage is read only by the second stage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : lfs_sync

/* verification/lfs_laser_model.sv */
// analog model of the laser pins with switchable shorts
module lfs_laser_model (
    input wire lfs_pkg::lfs_test_drive_type test_drive,
    input wire logic rbin_gnd,
    input wire logic lco_gnd,
    input wire logic lco_sup,
    input wire logic det_dead,
    output lfs_pkg::lfs_sense_type sense
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------------
    // pin comparators
    // ----------------------------------------------------------------------
    // a short wins; injection pulls the pin low unless the detector is dead
    assign sense.rbin_low = rbin_gnd;
    assign sense.lco_low = lco_gnd | (test_drive.inject & ~det_dead);
    assign sense.lco_high = lco_sup; // pull-down cannot beat a supply short
endmodule : lfs_laser_model

/* verification/testbench.sv */
// self-checking bench of the laser fault safety control
`include "lfs_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    lfs_pkg::lfs_sense_type sense;
    lfs_pkg::lfs_test_drive_type test_drive;
    logic power_down_n = 1'h1;
    logic illum_window = 1'h0;
    logic laser_supply_enable_n;
    logic laser_drive_en;
    logic irq;
    logic [7:0] laser_power_cfg_a;
    logic [7:0] laser_power_cfg_b;
    logic rbin_gnd = 1'h0;
    logic lco_gnd = 1'h0;
    logic lco_sup = 1'h0;
    logic det_dead = 1'h0;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 32'he2da;
    int cycles = 0;
    logic [31:0] rd;
    logic sh, pd, il;

    // ----------------------------------------------------------------------
    // design and pin model
    // ----------------------------------------------------------------------
    lfs_laser_safety dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sense(sense), .power_down_n(power_down_n), .illum_window(illum_window),
        .laser_supply_enable_n(laser_supply_enable_n), .laser_drive_en(laser_drive_en),
        .laser_power_cfg_a(laser_power_cfg_a), .laser_power_cfg_b(laser_power_cfg_b),
        .test_drive(test_drive), .irq(irq));
    lfs_laser_model pins (.test_drive(test_drive), .rbin_gnd(rbin_gnd), .lco_gnd(lco_gnd),
        .lco_sup(lco_sup), .det_dead(det_dead), .sense(sense));

    // clock, 5 ns period
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // cycle count and hang limit
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic logic exp_drive(input logic f, input logic s, input logic p,
        input logic i);
        return !f & p & (!s | i);
    endfunction : exp_drive

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr

    // read data taken in the cycle after the read edge
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 rd = reg_rdata;
    endtask : rdr

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // one self-test from a config write; len is the expected run length
    task automatic selftest(input logic fl, input int len);
        int t0;
        logic [7:0] v;
        v = 8'($random(seed));
        wr(`LFS_OFS_CFG_A, {24'h0, v});
        #1 t0 = cycles;
        chk("cfg_a", {24'h0, v}, {24'h0, laser_power_cfg_a});
        chk("pull_up", 32'h4, {29'h0, test_drive});
        chk("drive_in_test", 32'h0, {31'h0, laser_drive_en});
        for (int i = 0; i < 400; i++) begin
            rdr(`LFS_OFS_STATUS);
            if (!rd[`LFS_ST_TEST_BUSY]) break;
        end
        chk("test_len", 32'h1, {31'h0, (cycles - t0 >= len - 2) && (cycles - t0 <= len + 8)});
        chk("test_fail", {31'h0, fl}, {31'h0, rd[`LFS_ST_TEST_FAIL]});
        chk("supply_en_n", {31'h0, fl}, {31'h0, laser_supply_enable_n});
        rdr(`LFS_OFS_INT_STAT);
        chk("done_int", 32'h1, {31'h0, rd[`LFS_INT_TEST_DONE]});
        wr(`LFS_OFS_INT_STAT, 32'h7);
        wr(`LFS_OFS_CTRL, 32'h3);
        #1 chk("cleared", 32'h0, {31'h0, laser_supply_enable_n});
    endtask : selftest

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'h0;
        #1 chk("rst_supply", 32'h0, {31'h0, laser_supply_enable_n});
        chk("rst_irq", 32'h0, {31'h0, irq});
        rdr(`LFS_OFS_CTRL);
        chk("ctrl_rst", 32'h1, rd);
        rdr(8'h20);
        chk("unmapped", 32'h0, rd);
        wr(`LFS_OFS_CFG_B, 32'h15a);
        #1 chk("cfg_b", 32'h5a, {24'h0, laser_power_cfg_b});
        // random drive modes, power-down and illumination window
        for (int i = 0; i < 16; i++) begin
            sh = 1'($random(seed));
            pd = 1'($random(seed));
            il = 1'($random(seed));
            wr(`LFS_OFS_CTRL, {31'h0, sh});
            power_down_n <= pd;
            illum_window <= il;
            tick(4);
            chk("drive_en", {31'h0, exp_drive(1'h0, sh, pd, il)}, {31'h0, laser_drive_en});
            chk("supply_ok", 32'h0, {31'h0, laser_supply_enable_n});
            rdr(`LFS_OFS_STATUS);
            chk("pd_status", {31'h0, !pd}, {31'h0, rd[`LFS_ST_POWER_DOWN]});
        end
        power_down_n <= 1'h1;
        wr(`LFS_OFS_CTRL, 32'h1);
        // restart by a second write, then supply short, then dead detector
        wr(`LFS_OFS_CFG_A, 32'h11);
        tick(100);
        selftest(1'h0, 600);
        lco_sup <= 1'h1;
        selftest(1'h1, 400);
        lco_sup <= 1'h0;
        det_dead <= 1'h1;
        selftest(1'h1, 600);
        det_dead <= 1'h0;
        // ground shorts on either pin at a random moment
        for (int p = 0; p < 2; p++) begin
            wr(`LFS_OFS_CTRL, 32'h0);
            tick(2 + ($random(seed) & 32'h7));
            if (p == 1) lco_gnd <= 1'h1;
            else rbin_gnd <= 1'h1;
            tick(2);
            chk("early", 32'h0, {31'h0, laser_supply_enable_n});
            tick(1);
            chk("fault_off", 32'h1, {31'h0, laser_supply_enable_n});
            chk("src_off", 32'h0, {31'h0, laser_drive_en});
            chk("irq_masked", 32'h0, {31'h0, irq});
            wr(`LFS_OFS_INT_MASK, 32'h1);
            #1 chk("irq_on", 32'h1, {31'h0, irq});
            wr(`LFS_OFS_CTRL, 32'h2);
            tick(1);
            chk("held", 32'h1, {31'h0, laser_supply_enable_n});
            rbin_gnd <= 1'h0;
            lco_gnd <= 1'h0;
            tick(4);
            wr(`LFS_OFS_CTRL, 32'h2);
            #1 chk("released", 32'h0, {31'h0, laser_supply_enable_n});
            wr(`LFS_OFS_INT_STAT, 32'h1);
            #1 chk("irq_clr", 32'h0, {31'h0, irq});
            wr(`LFS_OFS_INT_MASK, 32'h0);
        end
        complete_run();
    end
endmodule : testbench
